// File: hw/pic_params.svh
// offsets, field positions, reset values and counts of the port control regs
`ifndef PIC_PARAMS_SVH
`define PIC_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets on the management bus
// ----------------------------------------------------------------
`define PIC_REG_IRQ 5'h1b
`define PIC_REG_CTL1 5'h1e
`define PIC_REG_CTL2 5'h1f

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PIC_IRQ_EN_HI 15
`define PIC_IRQ_EN_LO 8
`define PIC_IRQ_FL_HI 7
`define PIC_IRQ_FL_LO 0
`define PIC_C1_LED_HI 15
`define PIC_C1_LED_LO 14
`define PIC_C1_POL 13
`define PIC_C1_XSTATE 11
`define PIC_C1_RLOOP 7
`define PIC_C2_XALG 15
`define PIC_C2_XSEL 14
`define PIC_C2_XDIS 13
`define PIC_C2_ENERGY 12
`define PIC_C2_FLINK 11
`define PIC_C2_ILVL 9

// ----------------------------------------------------------------
// reset values, frame counts, op codes and led modes
// ----------------------------------------------------------------
`define PIC_XALG_RST 1'h1
`define PIC_IRQ_PIN_RST 1'h1
`define PIC_PRE_ONES 6'h20
`define PIC_HDR_LAST 5'h0c
`define PIC_TA_LAST 5'h01
`define PIC_DATA_BITS 5'h10
`define PIC_DATA_LAST 5'h0f
`define PIC_OP_READ 2'h2
`define PIC_OP_WRITE 2'h1
`define PIC_LED_SPEED 2'h0
`define PIC_LED_ACT 2'h1

`endif

// File: hw/pic_pkg.sv
// types shared by the port control register bank
package pic_pkg;

   typedef enum logic [2:0] {
      S_PRE, S_HDR, S_RTA, S_RDAT, S_WTA, S_WDAT
   } pic_fsm_t;

   // wire-side status sampled into the control registers
   typedef struct packed {
      logic polarity_reversed;
      logic crossover_state;
      logic energy_detect;
   } pic_stat_t;

   // control levels handed to the line-side logic
   typedef struct packed {
      logic remote_loopback;
      logic crossover_algorithm_select;
      logic crossover_manual_swap;
      logic crossover_auto_disable;
      logic force_link_pass;
   } pic_ctrl_t;

   typedef struct packed {
      pic_fsm_t fsm;
      logic mdc_q;
      logic [5:0] ones;
      logic [4:0] cnt;
      logic [15:0] sh;
      logic [4:0] reg_a;
      logic [7:0] en;
      logic [7:0] flags;
      logic [1:0] led_mode;
      pic_ctrl_t ctrl;
      logic int_lvl;
      logic irq;
      logic led_a;
      logic led_b;
      logic mdio_o;
      logic mdio_oe;
   } pic_state_t;

endpackage

// File: hw/pic_regs.sv
// management-bus register bank: event interrupts, leds and crossover control
`timescale 1ns/1ps
`include "pic_params.svh"

module pic_regs (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [4:0] phy_addr,
   input wire logic mdc,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe,
   input wire logic [7:0] link_events,
   input wire pic_pkg::pic_stat_t line_stat,
   input wire logic link_up,
   input wire logic activity,
   input wire logic speed_100,
   output pic_pkg::pic_ctrl_t line_ctrl,
   output logic irq_pin,
   output logic led_pin_a,
   output logic led_pin_b
);

   pic_pkg::pic_state_t st_r;
   pic_pkg::pic_state_t st_nxt;
   logic rise;
   logic fall;
   logic rd_go;
   logic wr_go;
   logic [15:0] wr_val;
   logic [12:0] hdr;

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   function automatic logic [15:0] read_reg(
      input logic [4:0] a,
      input pic_pkg::pic_state_t s,
      input pic_pkg::pic_stat_t ls
   );
      logic [15:0] d;
      d = 16'h0000;
      case (a)
         `PIC_REG_IRQ: begin
            d[`PIC_IRQ_EN_HI:`PIC_IRQ_EN_LO] = s.en;
            d[`PIC_IRQ_FL_HI:`PIC_IRQ_FL_LO] = s.flags;
         end
         `PIC_REG_CTL1: begin
            d[`PIC_C1_LED_HI:`PIC_C1_LED_LO] = s.led_mode;
            d[`PIC_C1_POL] = ls.polarity_reversed;
            d[`PIC_C1_XSTATE] = ls.crossover_state;
            d[`PIC_C1_RLOOP] = s.ctrl.remote_loopback;
         end
         `PIC_REG_CTL2: begin
            d[`PIC_C2_XALG] = s.ctrl.crossover_algorithm_select;
            d[`PIC_C2_XSEL] = s.ctrl.crossover_manual_swap;
            d[`PIC_C2_XDIS] = s.ctrl.crossover_auto_disable;
            d[`PIC_C2_ENERGY] = ls.energy_detect;
            d[`PIC_C2_FLINK] = s.ctrl.force_link_pass;
            d[`PIC_C2_ILVL] = s.int_lvl;
         end
         default: d = 16'h0000;
      endcase
      return d;
   endfunction

   assign rise = mdc && !st_r.mdc_q;
   assign fall = !mdc && st_r.mdc_q;

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_nxt = st_r;
      rd_go = 1'b0;
      wr_go = 1'b0;
      wr_val = 16'h0000;
      hdr = {st_r.sh[11:0], mdio_i};
      st_nxt.mdc_q = mdc;
      // mdio is sampled on mdc rising edges, driven after falling ones
      case (st_r.fsm)
         pic_pkg::S_PRE: begin
            if (rise) begin
               if (mdio_i) begin
                  if (st_r.ones != `PIC_PRE_ONES) begin
                     st_nxt.ones = 6'(st_r.ones + 6'h01);
                  end
               end else if (st_r.ones == `PIC_PRE_ONES) begin
                  st_nxt.fsm = pic_pkg::S_HDR;
                  st_nxt.cnt = 5'h00;
                  st_nxt.ones = 6'h00;
               end else begin
                  st_nxt.ones = 6'h00;
               end
            end
         end
         pic_pkg::S_HDR: begin
            if (rise) begin
               st_nxt.sh = {st_r.sh[14:0], mdio_i};
               st_nxt.cnt = 5'(st_r.cnt + 5'h01);
               if (st_r.cnt == `PIC_HDR_LAST) begin
                  st_nxt.cnt = 5'h00;
                  st_nxt.reg_a = hdr[4:0];
                  st_nxt.fsm = pic_pkg::S_PRE;
                  if (hdr[12] && hdr[9:5] == phy_addr) begin
                     if (hdr[11:10] == `PIC_OP_READ) begin
                        rd_go = 1'b1;
                        st_nxt.sh = read_reg(hdr[4:0], st_r, line_stat);
                        st_nxt.fsm = pic_pkg::S_RTA;
                     end else if (hdr[11:10] == `PIC_OP_WRITE) begin
                        st_nxt.fsm = pic_pkg::S_WTA;
                     end
                  end
               end
            end
         end
         pic_pkg::S_RTA: begin
            if (fall) begin
               st_nxt.cnt = 5'(st_r.cnt + 5'h01);
               if (st_r.cnt == `PIC_TA_LAST) begin
                  st_nxt.mdio_oe = 1'b1;
                  st_nxt.mdio_o = 1'b0;
                  st_nxt.cnt = 5'h00;
                  st_nxt.fsm = pic_pkg::S_RDAT;
               end
            end
         end
         pic_pkg::S_RDAT: begin
            if (fall) begin
               if (st_r.cnt == `PIC_DATA_BITS) begin
                  st_nxt.mdio_oe = 1'b0;
                  st_nxt.mdio_o = 1'b0;
                  st_nxt.cnt = 5'h00;
                  st_nxt.fsm = pic_pkg::S_PRE;
               end else begin
                  st_nxt.mdio_o = st_r.sh[15];
                  st_nxt.sh = {st_r.sh[14:0], 1'b0};
                  st_nxt.cnt = 5'(st_r.cnt + 5'h01);
               end
            end
         end
         pic_pkg::S_WTA: begin
            if (rise) begin
               st_nxt.cnt = 5'(st_r.cnt + 5'h01);
               if (st_r.cnt == `PIC_TA_LAST) begin
                  st_nxt.cnt = 5'h00;
                  st_nxt.fsm = pic_pkg::S_WDAT;
               end
            end
         end
         pic_pkg::S_WDAT: begin
            if (rise) begin
               st_nxt.sh = {st_r.sh[14:0], mdio_i};
               st_nxt.cnt = 5'(st_r.cnt + 5'h01);
               if (st_r.cnt == `PIC_DATA_LAST) begin
                  wr_go = 1'b1;
                  wr_val = {st_r.sh[14:0], mdio_i};
                  st_nxt.cnt = 5'h00;
                  st_nxt.fsm = pic_pkg::S_PRE;
               end
            end
         end
         default: begin
            st_nxt.fsm = pic_pkg::S_PRE;
         end
      endcase

      // ----------------------------------------------------------------
      // register writes
      // ----------------------------------------------------------------
      if (wr_go) begin
         case (st_r.reg_a)
            `PIC_REG_IRQ: begin
               st_nxt.en = wr_val[`PIC_IRQ_EN_HI:`PIC_IRQ_EN_LO];
            end
            `PIC_REG_CTL1: begin
               st_nxt.led_mode = wr_val[`PIC_C1_LED_HI:`PIC_C1_LED_LO];
               st_nxt.ctrl.remote_loopback = wr_val[`PIC_C1_RLOOP];
            end
            `PIC_REG_CTL2: begin
               st_nxt.ctrl.crossover_algorithm_select =
                  wr_val[`PIC_C2_XALG];
               st_nxt.ctrl.crossover_manual_swap =
                  wr_val[`PIC_C2_XSEL];
               st_nxt.ctrl.crossover_auto_disable =
                  wr_val[`PIC_C2_XDIS];
               st_nxt.ctrl.force_link_pass = wr_val[`PIC_C2_FLINK];
               st_nxt.int_lvl = wr_val[`PIC_C2_ILVL];
            end
            default: begin
               st_nxt.en = st_r.en;
            end
         endcase
      end

      // flags are snapshotted at the read, so an event in that cycle
      // survives the clear and shows on the next read
      if (rd_go && hdr[4:0] == `PIC_REG_IRQ) begin
         st_nxt.flags = 8'h00;
      end
      st_nxt.flags = st_nxt.flags | link_events;

      // pin polarity follows the level bit even with nothing pending
      st_nxt.irq = (|(st_nxt.flags & st_nxt.en)) ? st_nxt.int_lvl
                                                 : !st_nxt.int_lvl;

      // reserved modes keep both leds dark
      case (st_nxt.led_mode)
         `PIC_LED_SPEED: begin
            st_nxt.led_b = speed_100;
            st_nxt.led_a = link_up && !activity;
         end
         `PIC_LED_ACT: begin
            st_nxt.led_b = activity;
            st_nxt.led_a = link_up;
         end
         default: begin
            st_nxt.led_b = 1'b0;
            st_nxt.led_a = 1'b0;
         end
      endcase
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_r <= '0;
         st_r.fsm <= pic_pkg::S_PRE;
         // mdc idles high; a low copy here would fake a rise after reset
         st_r.mdc_q <= 1'b1;
         st_r.ctrl.crossover_algorithm_select <= `PIC_XALG_RST;
         st_r.irq <= `PIC_IRQ_PIN_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign mdio_o = st_r.mdio_o;
   assign mdio_oe = st_r.mdio_oe;
   assign line_ctrl = st_r.ctrl;
   assign irq_pin = st_r.irq;
   assign led_pin_a = st_r.led_a;
   assign led_pin_b = st_r.led_b;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   sequence s_ta_last;
      st_r.fsm == pic_pkg::S_RTA && fall && st_r.cnt == `PIC_TA_LAST;
   endsequence

   property p_en_write;
      wr_go && st_r.reg_a == `PIC_REG_IRQ |=> st_r.en == $past(wr_val[15:8]);
   endproperty
   a_en_write: assert property (p_en_write)
      else $error("enable bits not written");

   property p_flag_set;
      |link_events |=> (st_r.flags & $past(link_events)) == $past(link_events);
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("event flag not set");

   property p_read_clear;
      rd_go && hdr[4:0] == `PIC_REG_IRQ && link_events == 8'h00
         |=> st_r.flags == 8'h00;
   endproperty
   a_read_clear: assert property (p_read_clear)
      else $error("flags not cleared on read");

   property p_write_keeps;
      wr_go && link_events == 8'h00 |=> st_r.flags == $past(st_r.flags);
   endproperty
   a_write_keeps: assert property (p_write_keeps)
      else $error("write touched flags");

   property p_irq_level;
      irq_pin == ((|(st_r.flags & st_r.en)) == st_r.int_lvl);
   endproperty
   a_irq_level: assert property (p_irq_level)
      else $error("irq pin level wrong");

   property p_led_speed;
      st_nxt.led_mode == `PIC_LED_SPEED |=> led_pin_b == $past(speed_100);
   endproperty
   a_led_speed: assert property (p_led_speed)
      else $error("led b not showing speed");

   property p_xalg_reset;
      $fell(rst) |-> st_r.ctrl.crossover_algorithm_select == 1'b1;
   endproperty
   a_xalg_reset: assert property (p_xalg_reset)
      else $error("crossover algorithm reset wrong");

   property p_energy_read;
      rd_go && hdr[4:0] == `PIC_REG_CTL2
         |=> st_r.sh[12] == $past(line_stat.energy_detect);
   endproperty
   a_energy_read: assert property (p_energy_read)
      else $error("energy detect not read");

   property p_flink_write;
      wr_go && st_r.reg_a == `PIC_REG_CTL2
         |=> line_ctrl.force_link_pass == $past(wr_val[11]);
   endproperty
   a_flink_write: assert property (p_flink_write)
      else $error("force link not written");

   property p_ta_drive;
      s_ta_last |=> mdio_oe && !mdio_o;
   endproperty
   a_ta_drive: assert property (p_ta_drive)
      else $error("turnaround zero not driven");

endmodule

// File: verif/pic_mgmt_host.sv
// station management controller model that drives management frames
`timescale 1ns/1ps
`include "pic_params.svh"
module pic_mgmt_host (
   input wire logic clk_sys,
   output logic mdc,
   output logic mdio_i,
   input wire logic mdio_o,
   input wire logic mdio_oe
);
   logic drv;
   logic dat;
   // pull-up: a released wire reads 1, never a stale bit
   assign mdio_i = mdio_oe ? mdio_o : (drv ? dat : 1'b1);
   initial begin
      mdc = 1'b1;
      drv = 1'b0;
      dat = 1'b1;
   end
   // ----
   // one bit: low phase 3 clocks, high phase 4 with the next call's edge
   // ----
   task automatic put_bit(input logic d, input logic en, output logic q);
      @(posedge clk_sys);
      mdc <= 1'b0;
      drv <= en;
      dat <= d;
      repeat (3) @(posedge clk_sys);
      mdc <= 1'b1;
      q = mdio_i;
      repeat (3) @(posedge clk_sys);
   endtask
   // host releases the wire from turnaround on for reads
   task automatic frame(input logic [1:0] op, input logic [4:0] pa,
      input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rd);
      logic [63:0] w;
      logic q;
      w = {32'hffffffff, 2'h1, op, pa, ra, 2'h2, wd};
      for (int i = 63; i >= 0; i--) begin
         put_bit(w[i], (i > 17) || (op != `PIC_OP_READ), q);
         rd = {rd[14:0], q};
      end
      // trailing fall lets the bank drop its drive; clock then stands high
      put_bit(1'b1, 1'b0, q);
   endtask
endmodule

// File: verif/tb_top.sv
// self-checking bench of the port control register bank
`timescale 1ns/1ps
`include "pic_params.svh"
module tb_top;
   logic clk_sys;
   logic rst;
   logic [4:0] phy_addr;
   logic mdc;
   logic mdio_i;
   logic mdio_o;
   logic mdio_oe;
   logic [7:0] link_events;
   pic_pkg::pic_stat_t line_stat;
   logic link_up;
   logic activity;
   logic speed_100;
   pic_pkg::pic_ctrl_t line_ctrl;
   logic irq_pin;
   logic led_pin_a;
   logic led_pin_b;
   int miscompares;
   int num_checks;
   logic [15:0] rd;
   logic [15:0] c1;
   logic [15:0] c2;
   logic [7:0] en;
   logic [7:0] fl;
   logic lvl;

   initial clk_sys = 1'b0;
   always #2 clk_sys = ~clk_sys;

   pic_regs i_dut (.clk_sys(clk_sys), .rst(rst), .phy_addr(phy_addr),
      .mdc(mdc), .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
      .link_events(link_events), .line_stat(line_stat),
      .link_up(link_up), .activity(activity), .speed_100(speed_100),
      .line_ctrl(line_ctrl), .irq_pin(irq_pin),
      .led_pin_a(led_pin_a), .led_pin_b(led_pin_b));
   pic_mgmt_host i_host (.clk_sys(clk_sys), .mdc(mdc), .mdio_i(mdio_i),
      .mdio_o(mdio_o), .mdio_oe(mdio_oe));

   // ----
   // expectations and checks
   // ----
   function automatic logic [15:0] exp_c1(input logic [15:0] w);
      return {w[15:14], line_stat.polarity_reversed, 1'b0,
         line_stat.crossover_state, 3'h0, w[7], 7'h00};
   endfunction
   function automatic logic [15:0] exp_c2(input logic [15:0] w);
      return {w[15:13], line_stat.energy_detect, w[11], 1'b0, w[9], 9'h000};
   endfunction
   function automatic logic [4:0] exp_ctl(input logic [15:0] a,
      input logic [15:0] b);
      return {a[7], b[15], b[14], b[13], b[11]};
   endfunction
   function automatic logic [1:0] exp_led(input logic [1:0] m);
      case (m)
         2'h0: return {speed_100, link_up & !activity};
         2'h1: return {activity, link_up};
         default: return 2'h0;
      endcase
   endfunction
   task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t reg got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_pin(input logic [4:0] got, input logic [4:0] exp);
      num_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[FAIL] %0t pins got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rd_reg(input logic [4:0] ra);
      i_host.frame(`PIC_OP_READ, phy_addr, ra, 16'h0000, rd);
   endtask
   task automatic wr_reg(input logic [4:0] ra, input logic [15:0] d);
      i_host.frame(`PIC_OP_WRITE, phy_addr, ra, d, rd);
   endtask
   task automatic complete_run;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // about 80 frames of some 455 clocks each; hang cut well beyond that
   initial begin
      repeat (90000) @(posedge clk_sys);
      miscompares++;
      complete_run();
   end

   // ----
   // tests
   // ----
   initial begin
      void'($urandom(80687));
      rst = 1'b1;
      phy_addr = 5'($urandom);
      link_events = 8'h00;
      line_stat = 3'($urandom);
      {link_up, activity, speed_100} = 3'h0;
      miscompares = 0;
      num_checks = 0;
      repeat (12) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (2) @(posedge clk_sys);
      chk_pin(line_ctrl, 5'h08);
      chk_pin({4'h0, irq_pin}, 5'h01);
      rd_reg(`PIC_REG_IRQ);
      chk_reg(rd, 16'h0000);
      rd_reg(`PIC_REG_CTL1);
      chk_reg(rd, exp_c1(16'h0000));
      rd_reg(`PIC_REG_CTL2);
      chk_reg(rd, exp_c2(16'h8000));
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         c1 = (i == 0) ? 16'hffff : 16'($urandom);
         c2 = (i == 0) ? 16'hffff : 16'($urandom);
         line_stat <= 3'($urandom);
         wr_reg(`PIC_REG_CTL1, c1);
         wr_reg(`PIC_REG_CTL2, c2);
         rd_reg(`PIC_REG_CTL1);
         chk_reg(rd, exp_c1(c1));
         rd_reg(`PIC_REG_CTL2);
         chk_reg(rd, exp_c2(c2));
         chk_pin(line_ctrl, exp_ctl(c1, c2));
      end
      $display("test control done");
      for (int i = 0; i < 8; i++) begin
         fl = 8'h01 << i;
         en = (i == 3) ? ~fl : (8'($urandom) | fl);
         lvl = i[0];
         wr_reg(`PIC_REG_CTL2, {6'h00, lvl, 9'h000});
         wr_reg(`PIC_REG_IRQ, {en, 8'h00});
         link_events <= fl;
         @(posedge clk_sys);
         link_events <= 8'h00;
         repeat (3) @(posedge clk_sys);
         chk_pin({4'h0, irq_pin}, {4'h0, |(fl & en) ? lvl : !lvl});
         // ones written to the flags must not clear them
         wr_reg(`PIC_REG_IRQ, {en, 8'hff});
         rd_reg(`PIC_REG_IRQ);
         chk_reg(rd, {en, fl});
         rd_reg(`PIC_REG_IRQ);
         chk_reg(rd, {en, 8'h00});
         chk_pin({4'h0, irq_pin}, {4'h0, !lvl});
      end
      $display("test events done");
      for (int i = 0; i < 8; i++) begin
         wr_reg(`PIC_REG_CTL1, {i[1:0], 14'h0000});
         {link_up, activity, speed_100} <= 3'($urandom);
         repeat (3) @(posedge clk_sys);
         chk_pin({3'h0, led_pin_b, led_pin_a}, {3'h0, exp_led(i[1:0])});
      end
      $display("test leds done");
      wr_reg(`PIC_REG_CTL1, 16'h0000);
      i_host.frame(`PIC_OP_WRITE, phy_addr ^ 5'h01, `PIC_REG_CTL1,
         16'hffff, rd);
      i_host.frame(2'h0, phy_addr, `PIC_REG_CTL1, 16'hffff, rd);
      i_host.frame(`PIC_OP_READ, phy_addr ^ 5'h10, `PIC_REG_CTL1,
         16'h0000, rd);
      chk_reg(rd, 16'hffff);
      rd_reg(`PIC_REG_CTL1);
      chk_reg(rd, exp_c1(16'h0000));
      rd_reg(5'h10);
      chk_reg(rd, 16'h0000);
      $display("test refusals done");
      complete_run();
   end
endmodule
